//--- dv/xcvr_cfg_host.sv
// host model: issues set and query requests to the register bank
// assumes the bank answers one cycle after each request
`timescale 1ns/1ps
module xcvr_cfg_host (
	// clock
	input wire logic clk,
	// request and answer
	output xcvr_cfg_pkg::reg_cmd_t cmd,
	input wire logic cmd_ok,
	input wire logic cmd_err,
	input wire logic [7:0] rd_data
);
	initial cmd = '0;
	// released fields show inverted data so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] n, input logic [7:0] d,
			output logic [1:0] r, output logic [7:0] q);
		@(negedge clk) cmd = '{wr: w, rd: !w, num: n, data: d};
		@(negedge clk) cmd = '{wr: 1'b0, rd: 1'b0, num: ~n, data: ~d};
		r = {cmd_ok, cmd_err};
		q = rd_data;
	endtask
endmodule // xcvr_cfg_host

//--- dv/xcvr_cfg_regs_props.sv
// checker for the register bank ports
// assumes binding into xcvr_cfg_regs
`timescale 1ns/1ps
`include "xcvr_cfg_params.svh"
module xcvr_cfg_regs_props (
	// watched ports
	input wire logic clk,
	input wire logic sys_rst,
	input wire xcvr_cfg_pkg::reg_cmd_t cmd,
	input wire logic cmd_ok,
	input wire logic cmd_err,
	input wire logic [7:0] rd_data,
	input wire logic disconnect_req,
	input wire logic link_request,
	input wire logic auto_answer,
	input wire logic [7:0] bit_rate_code,
	input wire logic [16:0] bit_rate_bps,
	input wire logic [7:0] peer_group,
	input wire logic [7:0] group_id,
	input wire logic group_match,
	input wire logic analog_mode,
	input wire logic [5:0] line_is_input,
	input wire logic [5:0] line_out_allowed,
	input wire logic [1:0] tx_level_code,
	input wire logic signed [4:0] tx_level_dbm
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_req;
		cmd.wr || cmd.rd;
	endsequence
	sequence s_bad_rate;
		cmd.wr && cmd.num == `REG_BIT_RATE && (cmd.data == 8'h00 || cmd.data > `RATE_MAX);
	endsequence
	a_one_answer: assert property (s_req |=> cmd_ok != cmd_err)
		else $error("request not answered exactly once");
	a_no_stray_answer: assert property (!(cmd.wr || cmd.rd) |=> !cmd_ok && !cmd_err)
		else $error("answer without request");
	a_rd_data_hold: assert property (!cmd.rd |=> $stable(rd_data))
		else $error("read data moved without a read");
	a_bad_rate_kept: assert property (s_bad_rate |=> cmd_err && $stable(bit_rate_code))
		else $error("bad rate code accepted");
	a_rate_decode: assert property ($stable(bit_rate_code) && bit_rate_code == `RATE_MAX
		|-> bit_rate_bps == 17'h1C200) else $error("top rate decode wrong");
	a_level_dbm: assert property ($stable(tx_level_code)
		|-> tx_level_dbm == $signed(5'(tx_level_code)) * 5'sh5 - 5'sh5)
		else $error("transmit level decode wrong");
	a_line_dirs: assert property (line_out_allowed ==
		(~line_is_input & {{2{!analog_mode}}, 4'hF})) else $error("line output mask wrong");
	a_group_cmp: assert property (group_match == (peer_group == group_id))
		else $error("group compare wrong");
	a_answer_cause: assert property (!link_request |=> !auto_answer)
		else $error("answer without link request");
	a_disc_pulse: assert property (disconnect_req |=> !disconnect_req)
		else $error("disconnect pulse too long");
endmodule // xcvr_cfg_regs_props

bind xcvr_cfg_regs xcvr_cfg_regs_props u_props (.clk(clk), .sys_rst(sys_rst), .cmd(cmd),
	.cmd_ok(cmd_ok), .cmd_err(cmd_err), .rd_data(rd_data), .disconnect_req(disconnect_req),
	.link_request(link_request), .auto_answer(auto_answer), .bit_rate_code(bit_rate_code),
	.bit_rate_bps(bit_rate_bps), .peer_group(peer_group), .group_id(group_id),
	.group_match(group_match), .analog_mode(analog_mode), .line_is_input(line_is_input),
	.line_out_allowed(line_out_allowed), .tx_level_code(tx_level_code),
	.tx_level_dbm(tx_level_dbm));

//--- dv/xcvr_cfg_regs_test.sv
// self-checking bench for the configuration register bank
// assumes the host model drives every set and query request
`timescale 1ns/1ps
`include "xcvr_cfg_params.svh"
module xcvr_cfg_regs_test;
	logic clk = 0, sys_rst = 1, factory_restore = 0, link_request = 0, power_up_done = 0;
	logic echo_cmd_valid = 0, echo_cmd_val = 0, quiet_cmd_valid = 0, quiet_cmd_val = 0;
	logic format_cmd_valid = 0, format_cmd_val = 0, flow_cmd_valid = 0, rx_char_valid = 0;
	logic [7:0] flow_cmd_val = 8'h00, rx_char = 8'h00, peer_group = 8'h01;
	logic cmd_ok, cmd_err, disconnect_req, auto_answer, broadcast_enter, group_match, analog_mode;
	logic [7:0] rd_data, disconnect_char, setup_timeout_s, recovery_timeout_s, guard_ms;
	logic [7:0] bit_rate_code, flow_mode, group_id, node_id;
	logic [16:0] bit_rate_bps;
	logic [5:0] line_is_input, line_out_allowed;
	logic [1:0] tx_level_code;
	logic signed [4:0] tx_level_dbm;
	xcvr_cfg_pkg::reg_cmd_t cmd;
	xcvr_cfg_pkg::resp_mode_t resp_mode;
	int miscompares = 0, comparisons = 0;
	logic [7:0] model [256];
	localparam logic [7:0] nums [12] = '{`REG_AUTO_ANSWER, `REG_DISC_CHAR, `REG_SETUP_TMO,
		`REG_RECOV_TMO, `REG_GUARD, `REG_RESP_BITS, `REG_BIT_RATE, `REG_FLOW_BITS,
		`REG_GROUP_ID, `REG_NODE_ID, `REG_IO_CFG, `REG_TX_LEVEL};
	localparam logic [7:0] rsts [12] = '{8'h00, 8'h7E, 8'h0A, 8'h0A, 8'h14, 8'h05, 8'h04,
		8'h00, 8'h01, 8'h02, 8'hC1, 8'h03};

	always #50 clk = ~clk;
	// short millisecond so guard windows last tens of cycles
	xcvr_cfg_regs #(.GUARD_CYC_PER_MS(10)) uut (.*);
	xcvr_cfg_host host (.clk(clk), .cmd(cmd), .cmd_ok(cmd_ok), .cmd_err(cmd_err),
		.rd_data(rd_data));

	// ==========
	// shared tasks
	task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] n, input logic [7:0] e);
		logic [1:0] r;
		logic [7:0] q;
		host.xfer(1'b0, n, 8'h00, r, q);
		chk("read", 17'(e), 17'(q));
	endtask
	task automatic wr(input logic [7:0] n, input logic [7:0] d, input logic good);
		logic [1:0] r;
		logic [7:0] q;
		host.xfer(1'b1, n, d, r, q);
		chk("answer", good ? 17'h2 : 17'h1, 17'(r));
		// reserved io bit 1 is stored as zero
		if (good)
			model[n] = (n == `REG_IO_CFG) ? (d & 8'hFD) : d;
		rd(n, model[n]);
	endtask
	task automatic send(input logic [7:0] c);
		@(negedge clk);
		rx_char_valid = 1;
		rx_char = c;
		@(negedge clk);
		rx_char_valid = 0;
		rx_char = ~c;
	endtask
	task automatic trial(input int pre, input logic foreign, input int exp);
		int hits = 0;
		send(8'h41);
		repeat (pre) @(negedge clk);
		send(8'h2B);
		if (foreign) begin
			repeat (5) @(negedge clk);
			send(8'h41);
		end
		repeat (40) begin
			@(negedge clk);
			hits += (disconnect_req === 1'b1);
		end
		chk("disconnect", 17'(exp), 17'(hits));
	endtask
	task automatic test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========
	// scenarios
	task automatic t_defaults;
		foreach (nums[i]) begin
			model[nums[i]] = rsts[i];
			rd(nums[i], rsts[i]);
		end
		chk("bps", 17'h02580, bit_rate_bps);
		chk("dbm", 17'h0000A, 17'(tx_level_dbm));
	endtask
	task automatic t_ranges;
		logic [1:0] r;
		logic [7:0] q;
		wr(`REG_SETUP_TMO, `TMO_MAX_S, 1);
		wr(`REG_SETUP_TMO, 8'h3D, 0);
		wr(`REG_RECOV_TMO, 8'h00, 1);
		wr(`REG_RECOV_TMO, 8'hFF, 0);
		wr(`REG_BIT_RATE, 8'h00, 0);
		wr(`REG_BIT_RATE, 8'h0B, 0);
		wr(`REG_BIT_RATE, 8'h0A, 1);
		chk("bps", 17'h1C200, bit_rate_bps);
		wr(`REG_TX_LEVEL, 8'h04, 0);
		wr(`REG_TX_LEVEL, 8'h00, 1);
		chk("dbm", 17'h1FFFB, 17'(tx_level_dbm));
		wr(`REG_AUTO_ANSWER, 8'h02, 0);
		wr(`REG_FLOW_BITS, 8'h02, 0);
		wr(`REG_FLOW_BITS, `FLOW_SW, 1);
		wr(`REG_NODE_ID, 8'hFE, 1);
		wr(`REG_GROUP_ID, 8'h00, 1);
		chk("match", 17'h0, 17'(group_match));
		host.xfer(1'b1, 8'h01, 8'h00, r, q);
		chk("unmapped", 17'h1, 17'(r));
	endtask
	task automatic t_modes;
		@(negedge clk);
		{echo_cmd_valid, echo_cmd_val, quiet_cmd_valid, quiet_cmd_val} = 4'b1011;
		{format_cmd_valid, format_cmd_val, flow_cmd_valid} = 3'b101;
		flow_cmd_val = `FLOW_HW;
		@(negedge clk);
		{echo_cmd_valid, quiet_cmd_valid, format_cmd_valid} = 3'b000;
		flow_cmd_val = 8'h02;
		@(negedge clk);
		flow_cmd_valid = 0;
		rd(`REG_RESP_BITS, 8'h02);
		rd(`REG_FLOW_BITS, `FLOW_HW);
	endtask
	task automatic t_io;
		wr(`REG_IO_CFG, 8'h03, 1);
		rd(`REG_IO_CFG, 8'h01);
		chk("outs", 17'h0F, 17'(line_out_allowed));
		wr(`REG_IO_CFG, 8'h54, 1);
		chk("outs", 17'h2A, 17'(line_out_allowed));
		chk("dirs", 17'h15, 17'(line_is_input));
	endtask
	task automatic t_link;
		wr(`REG_AUTO_ANSWER, `AA_ANSWER, 1);
		link_request = 1;
		repeat (2) @(negedge clk);
		chk("answer", 17'h1, 17'(auto_answer));
		link_request = 0;
		wr(`REG_AUTO_ANSWER, `AA_BROADCAST, 1);
		power_up_done = 1;
		repeat (2) @(negedge clk);
		chk("broadcast", 17'h1, 17'(broadcast_enter));
		power_up_done = 0;
	endtask
	task automatic t_restore;
		@(negedge clk);
		factory_restore = 1;
		@(negedge clk);
		factory_restore = 0;
		rd(`REG_GUARD, `RST_GUARD);
		rd(`REG_BIT_RATE, `RST_BIT_RATE);
		chk("match", 17'h1, 17'(group_match));
	endtask

	initial begin
		repeat (2) @(negedge clk);
		sys_rst = 0;
		t_defaults;
		t_ranges;
		t_modes;
		t_io;
		t_link;
		wr(`REG_GUARD, 8'h02, 1);
		wr(`REG_DISC_CHAR, 8'h2B, 1);
		trial(30, 0, 1);
		trial(5, 0, 0);
		trial(30, 1, 0);
		t_restore;
		test_done;
	end
	initial begin
		#2000000;
		miscompares++;
		test_done;
	end
endmodule // xcvr_cfg_regs_test

//--- hdl/xcvr_cfg_params.svh
// register numbers, field positions, reset values and timing counts
// assumes inclusion by the register bank and its bench
`ifndef XCVR_CFG_PARAMS_SVH
`define XCVR_CFG_PARAMS_SVH

`define REG_AUTO_ANSWER 8'h00
`define REG_DISC_CHAR 8'h02
`define REG_SETUP_TMO 8'h07
`define REG_RECOV_TMO 8'h0A
`define REG_GUARD 8'h0C
`define REG_RESP_BITS 8'h0E
`define REG_BIT_RATE 8'h17
`define REG_FLOW_BITS 8'h27
`define REG_GROUP_ID 8'h68
`define REG_NODE_ID 8'h69
`define REG_IO_CFG 8'h6B
`define REG_TX_LEVEL 8'h6C

`define RST_AUTO_ANSWER 8'h00
`define RST_DISC_CHAR 8'h7E
`define RST_SETUP_TMO 8'h0A
`define RST_RECOV_TMO 8'h0A
`define RST_GUARD 8'h14
`define RST_RESP_BITS 8'h05
`define RST_BIT_RATE 8'h04
`define RST_FLOW_BITS 8'h00
`define RST_GROUP_ID 8'h01
`define RST_NODE_ID 8'h02
`define RST_IO_CFG 8'hC1
`define RST_TX_LEVEL 8'h03

`define AA_IGNORE 8'h00
`define AA_ANSWER 8'h01
`define AA_BROADCAST 8'h80

`define RESP_ECHO_BIT 0
`define RESP_QUIET_BIT 1
`define RESP_WORDS_BIT 2

`define FLOW_OFF 8'h00
`define FLOW_HW 8'h03
`define FLOW_SW 8'h04

`define IO_ANALOG_BIT 0
`define IO_DIR_LSB 2

`define TMO_MAX_S 8'h3C
`define RATE_MIN 8'h01
`define RATE_MAX 8'h0A

`define CLK_HZ 10000000
`define GUARD_UNIT_NS 1000000
`define CLK_PERIOD_NS 100
`define CYC_PER_MS (`GUARD_UNIT_NS / `CLK_PERIOD_NS)

`endif

//--- hdl/xcvr_cfg_pkg.sv
// types shared by the register bank and its bench
package xcvr_cfg_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] num;
		logic [7:0] data;
	} reg_cmd_t;

	typedef struct packed {
		logic echo_on;
		logic result_quiet;
		logic word_responses;
	} resp_mode_t;

	typedef enum logic [1:0] {
		G_IDLE = 2'b00,
		G_PRE = 2'b01,
		G_POST = 2'b10
	} guard_state_t;
endpackage

//--- hdl/xcvr_cfg_regs.sv
// configuration register bank of the transceiver's controller
// assumes a command parser on clk that turns set and query text into cmd pulses
// How it works
// - auto answer 0 ignore, 1 answer, 128 broadcast
// - disconnect character 8 bits, default 126
// - setup timeout 0-60 seconds, default 10
// - recovery timeout 0-60 seconds, default 10
// - guard window ms, default 20, both sides
// - foreign character in window cancels disconnect
// - response bits mirror echo, quiet, format
// - bit rate codes 1-10, default 4
// - flow register mirrors flow control command
// - group id default 1 filters peers
// - io bit 0 makes analog pins analog
// - io bits 2-7 set line directions
// - lines four, five output only if digital
// - transmit level codes 0-3, default 3
// - flow code 0 off, 3 hardware, 4 software
// - set writes register, query returns value
`timescale 1ns/1ps
`include "xcvr_cfg_params.svh"

module xcvr_cfg_regs #(
	parameter int GUARD_CYC_PER_MS = `CYC_PER_MS
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register commands from the parser
	input wire xcvr_cfg_pkg::reg_cmd_t cmd,
	input wire logic factory_restore,
	output logic cmd_ok,
	output logic cmd_err,
	output logic [7:0] rd_data,
	// mode commands
	input wire logic echo_cmd_valid,
	input wire logic echo_cmd_val,
	input wire logic quiet_cmd_valid,
	input wire logic quiet_cmd_val,
	input wire logic format_cmd_valid,
	input wire logic format_cmd_val,
	input wire logic flow_cmd_valid,
	input wire logic [7:0] flow_cmd_val,
	// serial character stream, in link data mode
	input wire logic rx_char_valid,
	input wire logic [7:0] rx_char,
	output logic disconnect_req,
	// link control
	input wire logic link_request,
	input wire logic power_up_done,
	output logic auto_answer,
	output logic broadcast_enter,
	input wire logic [7:0] peer_group,
	output logic group_match,
	// configuration outputs
	output logic [7:0] disconnect_char,
	output logic [7:0] setup_timeout_s,
	output logic [7:0] recovery_timeout_s,
	output logic [7:0] guard_ms,
	output xcvr_cfg_pkg::resp_mode_t resp_mode,
	output logic [7:0] bit_rate_code,
	output logic [16:0] bit_rate_bps,
	output logic [7:0] flow_mode,
	output logic [7:0] group_id,
	output logic [7:0] node_id,
	output logic analog_mode,
	output logic [5:0] line_is_input,
	output logic [5:0] line_out_allowed,
	output logic [1:0] tx_level_code,
	output logic signed [4:0] tx_level_dbm
);

	// ==========================================================
	// register storage
	logic [7:0] aa_r, dc_r, su_r, rc_r, gd_r, rs_r, br_r, fl_r, gi_r, ni_r, io_r, tl_r;

	wire is_aa = cmd.num == `REG_AUTO_ANSWER;
	wire is_dc = cmd.num == `REG_DISC_CHAR;
	wire is_su = cmd.num == `REG_SETUP_TMO;
	wire is_rc = cmd.num == `REG_RECOV_TMO;
	wire is_gd = cmd.num == `REG_GUARD;
	wire is_rs = cmd.num == `REG_RESP_BITS;
	wire is_br = cmd.num == `REG_BIT_RATE;
	wire is_fl = cmd.num == `REG_FLOW_BITS;
	wire is_gi = cmd.num == `REG_GROUP_ID;
	wire is_ni = cmd.num == `REG_NODE_ID;
	wire is_io = cmd.num == `REG_IO_CFG;
	wire is_tl = cmd.num == `REG_TX_LEVEL;
	wire mapped = is_aa | is_dc | is_su | is_rc | is_gd | is_rs | is_br | is_fl |
		is_gi | is_ni | is_io | is_tl;

	// out-of-range values are refused, so stored values stay documented
	wire aa_ok = cmd.data == `AA_IGNORE || cmd.data == `AA_ANSWER || cmd.data == `AA_BROADCAST;
	wire tmo_ok = cmd.data <= `TMO_MAX_S;
	wire br_ok = cmd.data >= `RATE_MIN && cmd.data <= `RATE_MAX;
	wire fl_ok = cmd.data == `FLOW_OFF || cmd.data == `FLOW_HW || cmd.data == `FLOW_SW;
	wire tl_ok = cmd.data <= 8'h03;
	wire val_ok = is_aa ? aa_ok : (is_su | is_rc) ? tmo_ok : is_br ? br_ok :
		is_fl ? fl_ok : is_tl ? tl_ok : 1'b1;
	wire wr_ok = cmd.wr && mapped && val_ok;
	wire bad = (cmd.wr || cmd.rd) && !(mapped && (cmd.rd || val_ok));
	wire [7:0] io_wr_val = {cmd.data[7:2], 1'b0, cmd.data[0]}; // reserved bit reads zero

	wire [7:0] next_rd_data = is_aa ? aa_r : is_dc ? dc_r : is_su ? su_r : is_rc ? rc_r :
		is_gd ? gd_r : is_rs ? rs_r : is_br ? br_r : is_fl ? fl_r : is_gi ? gi_r :
		is_ni ? ni_r : is_io ? io_r : is_tl ? tl_r : 8'h00;

	wire dflt = sys_rst || factory_restore;

	wire [7:0] next_rs = {5'h00,
		format_cmd_valid ? format_cmd_val : rs_r[`RESP_WORDS_BIT],
		quiet_cmd_valid ? quiet_cmd_val : rs_r[`RESP_QUIET_BIT],
		echo_cmd_valid ? echo_cmd_val : rs_r[`RESP_ECHO_BIT]};
	wire flow_cmd_ok = flow_cmd_valid && (flow_cmd_val == `FLOW_OFF ||
		flow_cmd_val == `FLOW_HW || flow_cmd_val == `FLOW_SW);

	always_ff @(posedge clk) begin
		if (dflt) begin
			aa_r <= `RST_AUTO_ANSWER;
			dc_r <= `RST_DISC_CHAR;
			su_r <= `RST_SETUP_TMO;
			rc_r <= `RST_RECOV_TMO;
			gd_r <= `RST_GUARD;
			rs_r <= `RST_RESP_BITS;
			br_r <= `RST_BIT_RATE;
			fl_r <= `RST_FLOW_BITS;
			gi_r <= `RST_GROUP_ID;
			ni_r <= `RST_NODE_ID;
			io_r <= `RST_IO_CFG;
			tl_r <= `RST_TX_LEVEL;
		end else begin
			if (wr_ok && is_aa) aa_r <= cmd.data;
			if (wr_ok && is_dc) dc_r <= cmd.data;
			if (wr_ok && is_su) su_r <= cmd.data;
			if (wr_ok && is_rc) rc_r <= cmd.data;
			if (wr_ok && is_gd) gd_r <= cmd.data;
			if (wr_ok && is_rs) rs_r <= {5'h00, cmd.data[2:0]};
			else rs_r <= next_rs;
			if (wr_ok && is_br) br_r <= cmd.data;
			if (wr_ok && is_fl) fl_r <= cmd.data;
			else if (flow_cmd_ok) fl_r <= flow_cmd_val;
			if (wr_ok && is_gi) gi_r <= cmd.data;
			if (wr_ok && is_ni) ni_r <= cmd.data;
			if (wr_ok && is_io) io_r <= io_wr_val;
			if (wr_ok && is_tl) tl_r <= cmd.data;
		end
	end

	// ==========================================================
	// command answers, one cycle after the request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_ok <= 1'b0;
			cmd_err <= 1'b0;
			rd_data <= 8'h00;
		end else begin
			cmd_ok <= (cmd.wr || cmd.rd) && !bad;
			cmd_err <= bad;
			if (cmd.rd && mapped) rd_data <= next_rd_data;
		end
	end

	// ==========================================================
	// disconnect guard: quiet, sequence character, quiet
	xcvr_cfg_pkg::guard_state_t gst;
	logic [13:0] ms_cnt;
	logic [7:0] ms_left;
	logic [7:0] quiet_ms;
	wire ms_tick = ms_cnt == 14'(GUARD_CYC_PER_MS - 1);
	wire quiet_ok = quiet_ms >= gd_r;
	wire disc_hit = rx_char_valid && rx_char == dc_r;

	always_ff @(posedge clk) begin
		if (sys_rst || rx_char_valid) ms_cnt <= 14'h0000;
		else if (ms_tick) ms_cnt <= 14'h0000;
		else ms_cnt <= ms_cnt + 14'h0001;
	end

	// saturating quiet time since the last character
	always_ff @(posedge clk) begin
		if (sys_rst || rx_char_valid) quiet_ms <= 8'h00;
		else if (ms_tick && quiet_ms != 8'hFF) quiet_ms <= quiet_ms + 8'h01;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gst <= xcvr_cfg_pkg::G_IDLE;
			ms_left <= 8'h00;
			disconnect_req <= 1'b0;
		end else begin
			disconnect_req <= 1'b0;
			unique case (gst)
				xcvr_cfg_pkg::G_IDLE: begin
					if (disc_hit && quiet_ok) begin
						gst <= xcvr_cfg_pkg::G_POST;
						ms_left <= gd_r;
					end
				end
				xcvr_cfg_pkg::G_POST: begin
					if (rx_char_valid) begin
						gst <= xcvr_cfg_pkg::G_IDLE;
					end else if (ms_left == 8'h00) begin
						gst <= xcvr_cfg_pkg::G_IDLE;
						disconnect_req <= 1'b1;
					end else if (ms_tick) begin
						ms_left <= ms_left - 8'h01;
					end
				end
				default: gst <= xcvr_cfg_pkg::G_IDLE;
			endcase
		end
	end

	// ==========================================================
	// link behaviour and outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			auto_answer <= 1'b0;
			broadcast_enter <= 1'b0;
		end else begin
			auto_answer <= link_request && aa_r == `AA_ANSWER;
			broadcast_enter <= power_up_done && aa_r == `AA_BROADCAST;
		end
	end

	assign group_match = peer_group == gi_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bit_rate_bps <= 17'd9600;
			tx_level_dbm <= 5'sd10;
		end else begin
			unique case (br_r[3:0])
				4'h1: bit_rate_bps <= 17'd1200;
				4'h2: bit_rate_bps <= 17'd2400;
				4'h3: bit_rate_bps <= 17'd4800;
				4'h5: bit_rate_bps <= 17'd14400;
				4'h6: bit_rate_bps <= 17'd19200;
				4'h7: bit_rate_bps <= 17'd28800;
				4'h8: bit_rate_bps <= 17'd38400;
				4'h9: bit_rate_bps <= 17'd57600;
				4'hA: bit_rate_bps <= 17'd115200;
				default: bit_rate_bps <= 17'd9600;
			endcase
			unique case (tl_r[1:0])
				2'h0: tx_level_dbm <= -5'sd5;
				2'h1: tx_level_dbm <= 5'sd0;
				2'h2: tx_level_dbm <= 5'sd5;
				2'h3: tx_level_dbm <= 5'sd10;
			endcase
		end
	end

	assign disconnect_char = dc_r;
	assign setup_timeout_s = su_r;
	assign recovery_timeout_s = rc_r;
	assign guard_ms = gd_r;
	assign resp_mode = {rs_r[`RESP_ECHO_BIT], rs_r[`RESP_QUIET_BIT], rs_r[`RESP_WORDS_BIT]};
	assign bit_rate_code = br_r;
	assign flow_mode = fl_r;
	assign group_id = gi_r;
	assign node_id = ni_r;
	assign analog_mode = io_r[`IO_ANALOG_BIT];
	assign line_is_input = io_r[7:`IO_DIR_LSB];
	// shared pins may drive only while the analog function is off
	assign line_out_allowed = {~io_r[7] & ~io_r[0], ~io_r[6] & ~io_r[0], ~io_r[5:2]};
	assign tx_level_code = tl_r[1:0];

endmodule // xcvr_cfg_regs
